//--- design/sac_adc_ctrl.sv
`timescale 1ns/1ps
`default_nettype none
// Notes on behaviour
// - codes 0-7 to channels 0-7, 8-11 to 10-13
// - disable bit 0 enables, 1 disables input
// - time bit picks 184 or 736 clocks
// - writing 1 to bit 6 starts conversion
// - start bit self-clears, reads back 0
// - short conversion takes 46 machine cycles
// - done flag 0 until conversion finishes
// - done flag is read-only
// - reading result clears done flag
// - restart mid-conversion begins from first step
// - sample taken 4 machine cycles after start
// - stop mode mid-conversion aborts it
// - stop after done keeps result
// - 8-bit SAR with mux and sample-hold
module sac_adc_ctrl (
    input wire logic i_clock,
    input wire logic i_srst,
    input wire logic i_awvalid,
    output logic o_awready,
    input wire logic [sac_pkg::ADDR_W-1:0] i_awaddr,
    input wire logic i_wvalid,
    output logic o_wready,
    input wire logic [31:0] i_wdata,
    input wire logic [3:0] i_wstrb,
    output logic o_bvalid,
    input wire logic i_bready,
    output logic [1:0] o_bresp,
    input wire logic i_arvalid,
    output logic o_arready,
    input wire logic [sac_pkg::ADDR_W-1:0] i_araddr,
    output logic o_rvalid,
    input wire logic i_rready,
    output logic [31:0] o_rdata,
    output logic [1:0] o_rresp,
    input wire logic i_stop_mode,
    input wire logic i_cmp,
    output logic [sac_pkg::NUM_AIN-1:0] o_chan_onehot,
    output logic o_ain_en,
    output logic o_sample,
    output logic [sac_pkg::RES_BITS-1:0] o_ladder_code,
    output logic o_busy
);
    // ----------------------------------------
    // bus slave
    // ----------------------------------------
    logic aw_held_ff;
    logic w_held_ff;
    logic [sac_pkg::ADDR_W-1:0] awaddr_ff;
    logic [7:0] wdata_ff;
    logic wstrb0_ff;
    logic do_write;
    logic ar_take;
    logic wr_ctrl;
    logic rd_res;
    logic rd_ctrl_ff;

    assign o_awready = !aw_held_ff && !o_bvalid;
    assign o_wready = !w_held_ff && !o_bvalid;
    assign o_arready = !o_rvalid;
    assign do_write = aw_held_ff && w_held_ff && !o_bvalid;
    assign ar_take = i_arvalid && o_arready;
    assign wr_ctrl = do_write && (awaddr_ff == sac_pkg::CTRL_ADDR) && wstrb0_ff;
    assign rd_res = ar_take && (i_araddr == sac_pkg::RES_ADDR);

    always_ff @(posedge i_clock) begin
        if (i_srst) begin
            aw_held_ff <= 1'b0;
            awaddr_ff <= '0;
        end else if (i_awvalid && o_awready) begin
            aw_held_ff <= 1'b1;
            awaddr_ff <= i_awaddr;
        end else if (do_write) begin
            aw_held_ff <= 1'b0;
        end
    end

    always_ff @(posedge i_clock) begin
        if (i_srst) begin
            w_held_ff <= 1'b0;
            wdata_ff <= 8'h00;
            wstrb0_ff <= 1'b0;
        end else if (i_wvalid && o_wready) begin
            w_held_ff <= 1'b1;
            wdata_ff <= i_wdata[7:0];
            wstrb0_ff <= i_wstrb[0];
        end else if (do_write) begin
            w_held_ff <= 1'b0;
        end
    end

    always_ff @(posedge i_clock) begin
        if (i_srst) begin
            o_bvalid <= 1'b0;
            o_bresp <= sac_pkg::RESP_OKAY;
        end else if (do_write) begin
            o_bvalid <= 1'b1;
            // result register is read-only, so a write to it is refused
            o_bresp <= (awaddr_ff == sac_pkg::CTRL_ADDR) ? sac_pkg::RESP_OKAY : sac_pkg::RESP_SLVERR;
        end else if (i_bready) begin
            o_bvalid <= 1'b0;
        end
    end

    // ----------------------------------------
    // control register
    // ----------------------------------------
    logic [3:0] chan_ff;
    logic dis_ff;
    logic long_ff;
    logic done_ff;
    logic start_req;
    logic set_done;
    logic [sac_pkg::RES_BITS-1:0] result_ff;

    // start is a pulse only; no storage, so it always reads 0
    assign start_req = wr_ctrl && wdata_ff[sac_pkg::START_BIT];

    always_ff @(posedge i_clock) begin
        if (i_srst) begin
            chan_ff <= sac_pkg::CTRL_RST[sac_pkg::CHAN_LSB +: sac_pkg::CHAN_W];
            dis_ff <= sac_pkg::CTRL_RST[sac_pkg::DIS_BIT];
            long_ff <= sac_pkg::CTRL_RST[sac_pkg::TIME_BIT];
        end else if (wr_ctrl) begin
            chan_ff <= wdata_ff[sac_pkg::CHAN_LSB +: sac_pkg::CHAN_W];
            dis_ff <= wdata_ff[sac_pkg::DIS_BIT];
            long_ff <= wdata_ff[sac_pkg::TIME_BIT];
        end
    end

    // set wins over a result read in the same cycle
    always_ff @(posedge i_clock) begin
        if (i_srst) begin
            done_ff <= sac_pkg::CTRL_RST[sac_pkg::DONE_BIT];
        end else if (set_done) begin
            done_ff <= 1'b1;
        end else if (start_req || rd_res) begin
            done_ff <= 1'b0;
        end
    end

    always_ff @(posedge i_clock) begin
        if (i_srst) begin
            o_rvalid <= 1'b0;
            o_rdata <= 32'h0000_0000;
            o_rresp <= sac_pkg::RESP_OKAY;
            rd_ctrl_ff <= 1'b0;
        end else if (ar_take) begin
            o_rvalid <= 1'b1;
            o_rdata <= 32'h0000_0000;
            o_rresp <= sac_pkg::RESP_OKAY;
            rd_ctrl_ff <= (i_araddr == sac_pkg::CTRL_ADDR);
            if (i_araddr == sac_pkg::CTRL_ADDR) begin
                o_rdata[7:0] <= {done_ff, 1'b0, long_ff, dis_ff, chan_ff};
            end else if (rd_res) begin
                o_rdata[7:0] <= result_ff;
            end else begin
                o_rresp <= sac_pkg::RESP_SLVERR;
            end
        end else if (i_rready) begin
            o_rvalid <= 1'b0;
        end
    end

    // ----------------------------------------
    // input multiplexer
    // ----------------------------------------
    always_comb begin
        o_chan_onehot = '0;
        if (!dis_ff && chan_ff < sac_pkg::CHAN_RSV_FIRST) begin
            if (chan_ff <= sac_pkg::CHAN_LOW_LAST) begin
                o_chan_onehot[chan_ff] = 1'b1;
            end else begin
                o_chan_onehot[chan_ff + 4'(sac_pkg::CHAN_HIGH_OFS)] = 1'b1;
            end
        end
    end
    assign o_ain_en = |o_chan_onehot;

    // ----------------------------------------
    // conversion sequencer
    // ----------------------------------------
    sac_pkg::sac_state_e state_ff;
    logic tick;
    logic [7:0] mc_cnt_ff;
    logic [7:0] st_cnt_ff;
    logic conv_long_ff;
    logic sar_init;
    logic sar_step;
    logic sar_busy;
    logic [7:0] total_mc;
    logic [7:0] step_mc;

    // restart also realigns the machine-cycle phase for exact timing
    sac_mcyc_div #(
        .DIV(sac_pkg::FC_PER_MCYC)
    ) u_div (
        .i_clock(i_clock),
        .i_srst(i_srst),
        .i_clear(start_req),
        .o_tick(tick)
    );

    sac_sar #(
        .W(sac_pkg::RES_BITS)
    ) u_sar (
        .i_clock(i_clock),
        .i_srst(i_srst),
        .i_init(sar_init),
        .i_step(sar_step),
        .i_cmp(i_cmp),
        .o_code(o_ladder_code),
        .o_busy(sar_busy)
    );

    assign total_mc = conv_long_ff ? sac_pkg::CONV_LONG_MC : sac_pkg::CONV_SHORT_MC;
    assign step_mc = conv_long_ff ? sac_pkg::STEP_LONG_MC : sac_pkg::STEP_SHORT_MC;
    assign sar_init = (state_ff == sac_pkg::SAC_TRACK) && tick && (mc_cnt_ff == sac_pkg::SAMPLE_MC - 8'h01);
    assign sar_step = (state_ff == sac_pkg::SAC_CONV) && tick && (st_cnt_ff == step_mc - 8'h01);
    assign set_done = (state_ff == sac_pkg::SAC_CONV) && tick && (mc_cnt_ff == total_mc - 8'h01)
                      && !start_req && !i_stop_mode;
    assign o_busy = (state_ff != sac_pkg::SAC_IDLE);

    always_ff @(posedge i_clock) begin
        if (i_srst) begin
            state_ff <= sac_pkg::SAC_IDLE;
        end else if (start_req) begin
            state_ff <= sac_pkg::SAC_TRACK;
        end else if (i_stop_mode) begin
            state_ff <= sac_pkg::SAC_IDLE;
        end else begin
            case (state_ff)
                sac_pkg::SAC_IDLE: begin
                    state_ff <= sac_pkg::SAC_IDLE;
                end
                sac_pkg::SAC_TRACK: begin
                    if (sar_init) begin
                        state_ff <= sac_pkg::SAC_CONV;
                    end
                end
                sac_pkg::SAC_CONV: begin
                    if (set_done) begin
                        state_ff <= sac_pkg::SAC_IDLE;
                    end
                end
                default: begin
                    state_ff <= sac_pkg::SAC_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge i_clock) begin
        if (i_srst || start_req) begin
            mc_cnt_ff <= 8'h00;
            st_cnt_ff <= 8'h00;
        end else if (tick && o_busy) begin
            mc_cnt_ff <= mc_cnt_ff + 8'h01;
            st_cnt_ff <= (sar_init || sar_step) ? 8'h00 : st_cnt_ff + 8'h01;
        end
    end

    always_ff @(posedge i_clock) begin
        if (i_srst) begin
            conv_long_ff <= 1'b0;
        end else if (start_req) begin
            conv_long_ff <= wdata_ff[sac_pkg::TIME_BIT];
        end
    end

    always_ff @(posedge i_clock) begin
        if (i_srst) begin
            o_sample <= 1'b0;
        end else begin
            o_sample <= sar_init && !start_req && !i_stop_mode;
        end
    end

    // an aborted conversion leaves the old value, which software must not trust
    always_ff @(posedge i_clock) begin
        if (i_srst) begin
            result_ff <= sac_pkg::RES_RST;
        end else if (set_done) begin
            result_ff <= o_ladder_code;
        end
    end

    // ----------------------------------------
    // checks
    // ----------------------------------------
    logic [10:0] cyc_ff;

    always_ff @(posedge i_clock) begin
        if (i_srst || start_req) begin
            cyc_ff <= 11'h000;
        end else if (o_busy) begin
            cyc_ff <= cyc_ff + 11'h001;
        end
    end

    default clocking cb @(posedge i_clock); endclocking
    default disable iff (i_srst);

    a_start_restarts: assert property (start_req |=> state_ff == sac_pkg::SAC_TRACK && !done_ff)
        else $error("start did not restart conversion");
    a_start_reads_zero: assert property (o_rvalid && rd_ctrl_ff |-> !o_rdata[sac_pkg::START_BIT])
        else $error("start bit read back as one");
    a_done_short_time: assert property ($rose(done_ff) && !conv_long_ff |-> cyc_ff == 11'(sac_pkg::CONV_SHORT_FC))
        else $error("short conversion length wrong");
    a_done_long_time: assert property ($rose(done_ff) && conv_long_ff |-> cyc_ff == 11'(sac_pkg::CONV_LONG_FC))
        else $error("long conversion length wrong");
    a_sample_moment: assert property (o_sample |-> cyc_ff == 11'(sac_pkg::SAMPLE_MCYC * sac_pkg::FC_PER_MCYC)
        && $past(tick))
        else $error("sample not at fourth machine cycle");
    a_done_low_busy: assert property (o_busy |-> !done_ff)
        else $error("done flag high during conversion");
    a_done_cleared_read: assert property (rd_res && !set_done |=> !done_ff)
        else $error("result read left done set");
    a_done_readonly: assert property ($rose(done_ff) |-> $past(set_done))
        else $error("done set without completion");
    a_result_loaded: assert property ($rose(done_ff) |-> result_ff == $past(o_ladder_code))
        else $error("result not loaded at completion");
    a_result_held: assert property (done_ff && !set_done |=> $stable(result_ff))
        else $error("result changed while done");
    a_stop_aborts: assert property (i_stop_mode && !start_req && o_busy |=> !o_busy && !done_ff)
        else $error("stop did not abort conversion");
    a_chan_high_map: assert property (!dis_ff && chan_ff == 4'hA |-> o_chan_onehot[12])
        else $error("channel code 10 not routed to channel 12");
    a_disable_path: assert property (dis_ff |-> o_chan_onehot == '0 && !o_ain_en)
        else $error("disabled input still routed");
    a_mcyc_period: assert property (tick && !start_req ##1 !start_req [*4]
        |-> tick && !$past(tick) && !$past(tick, 2) && !$past(tick, 3))
        else $error("machine cycle not four clocks");
    a_sar_steps: assert property (sar_init |=> sar_busy)
        else $error("approximation did not begin");

    c_short_done: cover property ($rose(done_ff) && !conv_long_ff);
    c_long_done: cover property ($rose(done_ff) && conv_long_ff);
    c_restart: cover property (o_busy && start_req);
    c_stop_abort: cover property (o_busy && i_stop_mode);
endmodule
`default_nettype wire

//--- design/sac_mcyc_div.sv
`timescale 1ns/1ps
`default_nettype none
// machine-cycle tick: one pulse every DIV clocks, phase reset by i_clear
module sac_mcyc_div #(
    parameter int DIV = 4
) (
    input wire logic i_clock,
    input wire logic i_srst,
    input wire logic i_clear,
    output logic o_tick
);
    localparam int CW = $clog2(DIV);
    logic [CW-1:0] cnt_ff;

    always_ff @(posedge i_clock) begin
        if (i_srst || i_clear || o_tick) begin
            cnt_ff <= '0;
        end else begin
            cnt_ff <= cnt_ff + CW'(1);
        end
    end

    assign o_tick = (cnt_ff == CW'(DIV - 1)) && !i_clear;
endmodule
`default_nettype wire

//--- design/sac_sar.sv
`timescale 1ns/1ps
`default_nettype none
// successive-approximation register: msb first, keep bit when input >= trial
module sac_sar #(
    parameter int W = 8
) (
    input wire logic i_clock,
    input wire logic i_srst,
    input wire logic i_init,
    input wire logic i_step,
    input wire logic i_cmp,
    output logic [W-1:0] o_code,
    output logic o_busy
);
    logic [W-1:0] mask_ff;

    always_ff @(posedge i_clock) begin
        if (i_srst) begin
            mask_ff <= '0;
            o_code <= '0;
        end else if (i_init) begin
            mask_ff <= {1'b1, {(W-1){1'b0}}};
            o_code <= {1'b1, {(W-1){1'b0}}};
        end else if (i_step && o_busy) begin
            mask_ff <= mask_ff >> 1;
            o_code <= (i_cmp ? o_code : (o_code & ~mask_ff)) | (mask_ff >> 1);
        end
    end

    assign o_busy = |mask_ff;
endmodule
`default_nettype wire

//--- include/sac_pkg.sv
package sac_pkg;
    // ----------------------------------------
    // timing
    // ----------------------------------------
    localparam int CLK_HZ = 20_000_000;
    localparam int FC_PER_MCYC = 4;
    localparam int CONV_SHORT_FC = 184;
    localparam int CONV_LONG_FC = 736;
    localparam int SAMPLE_MCYC = 4;
    localparam int RES_BITS = 8;
    localparam logic [7:0] CONV_SHORT_MC = 8'(CONV_SHORT_FC / FC_PER_MCYC);
    localparam logic [7:0] CONV_LONG_MC = 8'(CONV_LONG_FC / FC_PER_MCYC);
    localparam logic [7:0] SAMPLE_MC = 8'(SAMPLE_MCYC);
    // bit decisions spread evenly between sampling and completion
    localparam logic [7:0] STEP_SHORT_MC = 8'((CONV_SHORT_FC / FC_PER_MCYC - SAMPLE_MCYC) / RES_BITS);
    localparam logic [7:0] STEP_LONG_MC = 8'((CONV_LONG_FC / FC_PER_MCYC - SAMPLE_MCYC) / RES_BITS);
    // ----------------------------------------
    // register map
    // ----------------------------------------
    localparam int ADDR_W = 8;
    localparam int CTRL_IDX = 32'h0000_000E;
    localparam int RES_IDX = 32'h0000_000F;
    localparam logic [ADDR_W-1:0] CTRL_ADDR = ADDR_W'(CTRL_IDX * 4);
    localparam logic [ADDR_W-1:0] RES_ADDR = ADDR_W'(RES_IDX * 4);
    localparam int CHAN_LSB = 0;
    localparam int CHAN_W = 4;
    localparam int DIS_BIT = 4;
    localparam int TIME_BIT = 5;
    localparam int START_BIT = 6;
    localparam int DONE_BIT = 7;
    localparam logic [7:0] CTRL_RST = 8'h00;
    localparam logic [7:0] RES_RST = 8'h00;
    localparam logic [3:0] CHAN_LOW_LAST = 4'h7;
    localparam logic [3:0] CHAN_RSV_FIRST = 4'hC;
    localparam int CHAN_HIGH_OFS = 2;
    localparam int NUM_AIN = 14;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef enum logic [2:0] {
        SAC_IDLE = 3'b001,
        SAC_TRACK = 3'b010,
        SAC_CONV = 3'b100
    } sac_state_e;
endpackage

//--- testbench/sac_ain_model.sv
`timescale 1ns/1ps
`default_nettype none
// ----
// analog input mux with sample-and-hold
// ----
module sac_ain_model (
    input wire logic i_clock,
    input wire logic [13:0][7:0] i_level,
    input wire logic [13:0] i_chan_onehot,
    input wire logic i_sample,
    input wire logic [7:0] i_ladder_code,
    output logic o_cmp
);
    logic [7:0] held = 8'h00;
    logic [7:0] pick;
    always_comb begin
        // nothing routed: the cap sees a floating node, never a clean level
        pick = ~held;
        for (int k = 0; k < 14; k++) begin
            if (i_chan_onehot[k]) begin
                pick = i_level[k];
            end
        end
    end
    always @(posedge i_clock) begin
        if (i_sample) begin
            held <= pick;
        end
    end
    assign o_cmp = (held >= i_ladder_code);
endmodule
`default_nettype wire

//--- testbench/test_sac_adc_ctrl.sv
`timescale 1ns/1ps
`default_nettype none
module test_sac_adc_ctrl;
    logic clk = 1'b0, srst = 1'b1, awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
    logic arvalid = 1'b0, rready = 1'b0, stop = 1'b0, armed = 1'b0, pb = 1'b0, pbusy = 1'b0;
    logic [7:0] awaddr = 8'h00, araddr = 8'h00, rnd = 8'h53;
    logic [31:0] wdata = 32'h0000_0000;
    logic [3:0] wstrb = 4'hF;
    logic awready, wready, bvalid, arready, rvalid, ain_en, sample, busy, cmp;
    logic [1:0] bresp, rresp, rs;
    logic [31:0] rdata, rd;
    logic [13:0] onehot;
    logic [7:0] ladder;
    logic [13:0][7:0] lvl = '0;
    int fail_count = 0, n_compared = 0, cyc = 0, samp_at = -1, end_at = -1;
    int m_ctrl = 0, m_done = 0, m_res = 0;
    always #25 clk = ~clk;
    sac_adc_ctrl i_sac_adc_ctrl (.i_clock(clk), .i_srst(srst), .i_awvalid(awvalid), .o_awready(awready),
        .i_awaddr(awaddr), .i_wvalid(wvalid), .o_wready(wready), .i_wdata(wdata), .i_wstrb(wstrb),
        .o_bvalid(bvalid), .i_bready(bready), .o_bresp(bresp), .i_arvalid(arvalid), .o_arready(arready),
        .i_araddr(araddr), .o_rvalid(rvalid), .i_rready(rready), .o_rdata(rdata), .o_rresp(rresp),
        .i_stop_mode(stop), .i_cmp(cmp), .o_chan_onehot(onehot), .o_ain_en(ain_en), .o_sample(sample),
        .o_ladder_code(ladder), .o_busy(busy));
    sac_ain_model i_sac_ain_model (.i_clock(clk), .i_level(lvl), .i_chan_onehot(onehot), .i_sample(sample),
        .i_ladder_code(ladder), .o_cmp(cmp));
    // ----
    // timing monitor: cycle 0 is the first with bvalid of a start write
    // ----
    always @(negedge clk) begin
        if (armed && bvalid && !pb) begin
            cyc = 0;
            samp_at = -1;
            end_at = -1;
        end else begin
            cyc++;
        end
        if (sample && samp_at < 0) samp_at = cyc;
        if (!busy && pbusy && end_at < 0) end_at = cyc;
        pb = bvalid;
        pbusy = busy;
    end
    // ----
    // helpers
    // ----
    function automatic logic [7:0] lfsr(input logic [7:0] s);
        return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
    endfunction
    function automatic int chan_of(input int code);
        return (code < 8) ? code : code + 2;
    endfunction
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            fail_count++;
            $display("unexpected at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic summarize;
        $display("compared %0d mismatches %0d", n_compared, fail_count);
        if (fail_count == 0 && n_compared > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    task automatic hang;
        fail_count++;
        $display("unexpected at %0t: wait ran out", $time);
        summarize();
    endtask
    task automatic note(input string s);
        $display("test %s finished", s);
    endtask
    task automatic axi_wr(input logic [7:0] a, input logic [7:0] d, input logic [3:0] s, input logic [1:0] er);
        int n;
        logic ta, tw, tb;
        @(posedge clk);
        awvalid <= 1'b1;
        awaddr <= a;
        wvalid <= 1'b1;
        wdata <= {24'h00_0000, d};
        wstrb <= s;
        bready <= 1'b1;
        for (n = 0; n < 40; n++) begin
            @(negedge clk);
            ta = awvalid & awready;
            tw = wvalid & wready;
            tb = bvalid;
            rs = bresp;
            @(posedge clk);
            if (ta) awvalid <= 1'b0;
            if (tw) wvalid <= 1'b0;
            if (tb) break;
        end
        bready <= 1'b0;
        if (n == 40) hang();
        chk(32'(rs), 32'(er));
    endtask
    task automatic axi_rd(input logic [7:0] a, input logic [1:0] er);
        int n;
        logic ta, tr;
        @(posedge clk);
        arvalid <= 1'b1;
        araddr <= a;
        rready <= 1'b1;
        for (n = 0; n < 40; n++) begin
            @(negedge clk);
            ta = arvalid & arready;
            tr = rvalid;
            rd = rdata;
            rs = rresp;
            @(posedge clk);
            if (ta) arvalid <= 1'b0;
            if (tr) break;
        end
        rready <= 1'b0;
        if (n == 40) hang();
        chk(32'(rs), 32'(er));
    endtask
    task automatic set_ctrl(input logic [7:0] d);
        axi_wr(sac_pkg::CTRL_ADDR, d, 4'hF, sac_pkg::RESP_OKAY);
        m_ctrl = int'(d[5:0]);
        if (d[6]) m_done = 0;
    endtask
    task automatic chk_ctrl;
        axi_rd(sac_pkg::CTRL_ADDR, sac_pkg::RESP_OKAY);
        chk(rd, 32'(m_done * 128 + m_ctrl));
    endtask
    task automatic start(input int code, input logic lng);
        set_ctrl(8'(code));
        armed = 1'b1;
        set_ctrl(8'(code + 64 + (lng ? 32 : 0)));
        armed = 1'b0;
        chk(32'(busy), 32'h0000_0001);
        chk_ctrl();
    endtask
    task automatic finish(input logic lng, input int ch);
        int n;
        // polling only, no other traffic while converting
        for (n = 0; n < 1000 && busy !== 1'b0; n++) @(negedge clk);
        if (n == 1000) hang();
        m_done = 1;
        m_res = int'(lvl[ch]);
        chk(32'(ladder), 32'(m_res));
        chk_ctrl();
        chk(32'(samp_at), 32'(sac_pkg::SAMPLE_MCYC * sac_pkg::FC_PER_MCYC));
        chk(32'(end_at), 32'(lng ? sac_pkg::CONV_LONG_FC : sac_pkg::CONV_SHORT_FC));
    endtask
    task automatic take;
        axi_rd(sac_pkg::RES_ADDR, sac_pkg::RESP_OKAY);
        chk(rd, 32'(m_res));
        m_done = 0;
        chk_ctrl();
    endtask
    initial begin
        int k, code, exp;
        repeat (4) @(posedge clk);
        srst <= 1'b0;
        for (k = 0; k < 14; k++) begin
            rnd = lfsr(rnd);
            lvl[k] <= rnd;
        end
        @(negedge clk);
        chk(32'({awready, wready, arready, bvalid, rvalid, sample, busy}), 32'h0000_0070);
        chk(32'(ladder), 32'h0000_0000);
        chk(32'(onehot), 32'h0000_0001);
        chk_ctrl();
        axi_rd(sac_pkg::RES_ADDR, sac_pkg::RESP_OKAY);
        chk(rd, 32'(sac_pkg::RES_RST));
        note("reset");
        for (k = 0; k < 32; k++) begin
            set_ctrl(8'(k));
            @(negedge clk);
            exp = (k % 16 > 11 || k > 15) ? 0 : 1 << chan_of(k % 16);
            chk(32'(onehot), 32'(exp));
            chk(32'(ain_en), 32'(exp != 0));
            chk_ctrl();
        end
        note("routing");
        for (k = 0; k < 4; k++) begin
            rnd = lfsr(rnd);
            code = rnd % 12;
            start(code, k == 3);
            finish(k == 3, chan_of(code));
            if (k == 0) begin
                set_ctrl(8'(code + 128));
                chk_ctrl();
            end
            if (k == 1) begin
                @(posedge clk);
                stop <= 1'b1;
                repeat (4) @(posedge clk);
                stop <= 1'b0;
                chk_ctrl();
            end
            take();
        end
        note("conversions");
        start(code, 1'b0);
        repeat (60) @(posedge clk);
        rnd = lfsr(rnd);
        lvl[chan_of(code)] <= rnd;
        start(code, 1'b0);
        finish(1'b0, chan_of(code));
        take();
        note("restart");
        start(code, 1'b0);
        repeat (30) @(posedge clk);
        stop <= 1'b1;
        @(posedge clk);
        stop <= 1'b0;
        @(negedge clk);
        chk(32'(busy), 32'h0000_0000);
        repeat (200) @(posedge clk);
        chk_ctrl();
        axi_rd(sac_pkg::RES_ADDR, sac_pkg::RESP_OKAY);
        chk(rd, 32'(m_res));
        note("abort");
        axi_wr(8'h00, 8'h41, 4'hF, sac_pkg::RESP_SLVERR);
        axi_wr(sac_pkg::RES_ADDR, 8'h12, 4'hF, sac_pkg::RESP_SLVERR);
        axi_rd(8'h04, sac_pkg::RESP_SLVERR);
        chk(rd, 32'h0000_0000);
        axi_wr(sac_pkg::CTRL_ADDR, 8'h7F, 4'h0, sac_pkg::RESP_OKAY);
        chk_ctrl();
        chk(32'(busy), 32'h0000_0000);
        note("bus");
        summarize();
    end
endmodule
`default_nettype wire
